// ==== dv/cbl_downstream.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Downstream logic: reads the outputs once per evaluation
module cbl_downstream (
   input  wire logic       pclk,         // Common clock
   input  wire logic       presetn,      // Async reset, active low
   input  wire logic       cycle_strobe, // Evaluation pulse
   input  wire logic [7:0] status_in,    // Output bits of the block
   output logic [7:0]      seen_r,       // Last bits taken
   output logic [15:0]     evals_r       // Evaluations counted
);
   // Take the outputs only on the strobe, like a cyclic chart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_r  <= 8'h00;
         evals_r <= 16'h0000;
      end else if (cycle_strobe) begin
         seen_r  <= status_in;
         evals_r <= evals_r + 16'h0001;
      end
   end
endmodule // cbl_downstream
`default_nettype wire

// ==== dv/cyclic_binary_logic_blocks_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module cyclic_binary_logic_blocks_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic        cstb, off_q, str_q, cd_q, cd_n, sd_q, sd_n, carry, ovf;
   logic [7:0]  paddr, seen;
   logic [15:0] evals;
   logic [31:0] pwdata, prdata, word_out, rd;
   int          err_count = 0;
   int          checks_done = 0;
   ////////////////////////////////////////////////////////////
   // Design, short evaluation period of 4 pclk, 1 ms per cycle
   cbl_logic_blocks #(.SAMPLE_CLKS(4), .SAMPLE_US(1000)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .cycle_strobe(cstb),
      .off_delay_q(off_q), .stretch_q(str_q), .cd_q(cd_q), .cd_inverted_out(cd_n),
      .sd_q(sd_q), .sd_inverted_out(sd_n), .word_out(word_out), .carry_out(carry),
      .shift_overflow(ovf));
   cbl_downstream down_u (.pclk(pclk), .presetn(presetn), .cycle_strobe(cstb),
      .status_in({ovf, carry, sd_n, sd_q, cd_n, cd_q, str_q, off_q}), .seen_r(seen),
      .evals_r(evals));
   // Clock, 10 ns period
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Verdict and end of run
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 16) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // Wait for the next evaluation, bounded
   task automatic wait_eval;
      int i;
      for (i = 0; i < 16; i++) begin
         @(posedge pclk);
         #1;
         if (cstb === 1'b1) break;
      end
      if (i == 16) begin
         err_count++;
         report_and_stop();
      end
   endtask
   // Write one register, then let one evaluation pass
   task automatic wr_eval(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      wait_eval();
   endtask
   task automatic step(input logic [31:0] c);
      wr_eval(cbl_pkg::OFS_CTRL, c);
   endtask
   ////////////////////////////////////////////////////////////
   // Reset values and an unmapped address
   task automatic t_reset;
      apb(1'b0, cbl_pkg::OFS_STATUS, 32'h0);
      chk("status", rd, 32'h0000_0028);
      apb(1'b0, cbl_pkg::OFS_OFFDLY, 32'h0);
      chk("offdly", rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("slverr", {31'h0, er}, 32'h1);
      chk("unmapped", rd, 32'h0);
   endtask
   // Both flip-flops through set, hold, both, hold, clear
   task automatic t_flops;
      logic [4:0] sv = 5'b00101, rv = 5'b10100, cde = 5'b00011, sde = 5'b01111;
      for (int i = 0; i < 5; i++) begin
         step({25'h0, rv[i], sv[i], rv[i], sv[i], 3'b000});
         chk("cd_q", {31'h0, cd_q}, {31'h0, cde[i]});
         chk("cd_n", {31'h0, cd_n}, {31'h0, ~cde[i]});
         chk("sd_q", {31'h0, sd_q}, {31'h0, sde[i]});
         chk("sd_n", {31'h0, sd_n}, {31'h0, ~sde[i]});
      end
      @(posedge pclk);
      #1;
      chk("downstream", {24'h0, seen}, 32'h0000_0028);
   endtask
   // Off-delay: high follows input, falls T evaluations after the edge, one for T zero
   task automatic t_off(input logic [31:0] t);
      wr_eval(cbl_pkg::OFS_OFFDLY, t);
      step(32'h1);
      chk("off_q", {31'h0, off_q}, 32'h1);
      repeat ((t == 0) ? 1 : t) begin
         step(32'h0);
         chk("off_q", {31'h0, off_q}, 32'h1);
      end
      step(32'h0);
      chk("off_q", {31'h0, off_q}, 32'h0);
   endtask
   // Input back high mid-delay restarts the full delay
   task automatic t_cancel;
      step(32'h1);
      step(32'h0);
      step(32'h1);
      chk("off_q", {31'h0, off_q}, 32'h1);
      repeat (2) begin
         step(32'h0);
         chk("off_q", {31'h0, off_q}, 32'h1);
      end
      step(32'h0);
      chk("off_q", {31'h0, off_q}, 32'h0);
   endtask
   // Stretcher: minimum of T evaluations from the rising edge
   task automatic t_str(input logic [31:0] t);
      wr_eval(cbl_pkg::OFS_STRETCH, t);
      step(32'h2);
      chk("str_q", {31'h0, str_q}, 32'h1);
      repeat (((t == 0) ? 1 : t) - 1) begin
         step(32'h0);
         chk("str_q", {31'h0, str_q}, 32'h1);
      end
      step(32'h0);
      chk("str_q", {31'h0, str_q}, 32'h0);
   endtask
   // Long input, then clear with input high, then init with input high and clear low
   task automatic t_clr;
      repeat (4) step(32'h2);
      chk("str_q", {31'h0, str_q}, 32'h1);
      step(32'h0);
      chk("str_q", {31'h0, str_q}, 32'h0);
      step(32'h2);
      step(32'h6);
      chk("str_q", {31'h0, str_q}, 32'h0);
      step(32'h0);
      // Input rises on an evaluation edge, so the init pass is the first to see it high
      @(posedge pclk);
      apb(1'b1, cbl_pkg::OFS_CTRL, 32'h2);
      wr_eval(cbl_pkg::OFS_INIT, 32'h4);
      step(32'h2);
      chk("str_q", {31'h0, str_q}, 32'h0);
   endtask
   // Init pass with both start outputs high
   task automatic t_init;
      step(32'h0);
      wr_eval(cbl_pkg::OFS_INIT, 32'h7);
      chk("off_q", {31'h0, off_q}, 32'h1);
      chk("str_q", {31'h0, str_q}, 32'h1);
      wait_eval();
      chk("init_run", {30'h0, str_q, off_q}, 32'h3);
      wait_eval();
      chk("init_off", {30'h0, str_q, off_q}, 32'h2);
      repeat (2) wait_eval();
      chk("init_end", {30'h0, str_q, off_q}, 32'h0);
   endtask
   // Shifter table: word, count, result, carry, overflow
   task automatic t_shift;
      logic [31:0] wi [8] = '{32'hf, 32'hf, 32'h8000_0003, 32'hc000_0000, 32'h8000_0000,
                             32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
      logic [7:0]  ct [8] = '{8'h02, 8'hfe, 8'h1f, 8'he1, 8'hfc, 8'h00, 8'h20, 8'he0};
      logic [31:0] wo [8] = '{32'h3c, 32'h3, 32'h8000_0000, 32'h1, 32'h0800_0000,
                             32'hffff_ffff, 32'h0, 32'h0};
      logic [7:0]  ce = 8'b0000_1110, oe = 8'b1100_0000;
      for (int i = 0; i < 8; i++) begin
         wr_eval(cbl_pkg::OFS_WORD_IN, wi[i]);
         wr_eval(cbl_pkg::OFS_COUNT, {24'h0, ct[i]});
         chk("word_out", word_out, wo[i]);
         chk("carry", {31'h0, carry}, {31'h0, ce[i]});
         chk("ovf", {31'h0, ovf}, {31'h0, oe[i]});
      end
      apb(1'b0, cbl_pkg::OFS_STATUS, 32'h0);
      chk("status_shift", {30'h0, rd[7:6]}, 32'h2);
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      wait_eval();
      t_flops();
      t_off(32'h0);
      t_off(32'h2);
      t_cancel();
      t_str(32'h0);
      t_str(32'h3);
      t_clr();
      t_init();
      t_shift();
      report_and_stop();
   end
   // Run limit
   initial begin
      #500000;
      err_count++;
      report_and_stop();
   end
endmodule // cyclic_binary_logic_blocks_tb_top
`default_nettype wire

// ==== rtl/cbl_logic_blocks.sv ====
// Contract
// RQ1 - Off-delay holds output until time elapses
// RQ2 - Off-delay output high while input high
// RQ3 - Input return high cancels running delay
// RQ4 - Off-delay time zero gives one cycle
// RQ5 - High input at init is no edge
// RQ6 - Initialized high off-delay holds full time
// RQ7 - Stretcher rising edge sets output
// RQ8 - Stretcher holds until low and elapsed
// RQ9 - Stretcher clear forces output low anytime
// RQ10 - Stretcher time zero gives one cycle
// RQ11 - High input at init is no edge
// RQ12 - Initialized high stretcher holds pulse duration
// RQ13 - Set sets, clear clears, none holds
// RQ14 - Clear-dominant: both high gives low
// RQ15 - Set-dominant: both high gives high
// RQ16 - Inverted output always complements, defaults high
// RQ17 - Signed count shifts left or right
// RQ18 - Vacated bits filled with zeros
// RQ19 - Carry is last bit out, zero count
// RQ20 - Magnitude above 31 gives zero, overflow
// RQ21 - Durations in milliseconds, default zero
// RQ22 - Milliseconds converted to cycles, decremented
// RQ23 - All blocks evaluate on common strobe
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cbl_logic_blocks #(
   parameter int unsigned SAMPLE_CLKS = cbl_pkg::SAMPLE_CLKS_DEF, // Pclk per cycle
   parameter int unsigned SAMPLE_US   = cbl_pkg::SAMPLE_US_DEF    // Period in us
) (
   input  wire logic        pclk,            // Bus and logic clock
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB access phase
   input  wire logic        pwrite,          // APB direction
   input  wire logic [7:0]  paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic             pready,          // APB ready
   output logic [31:0]      prdata,          // APB read data
   output logic             pslverr,         // APB error, unmapped
   output logic             cycle_strobe,    // One pclk per evaluation
   output logic             off_delay_q,     // Off-delay timer output
   output logic             stretch_q,       // Pulse stretcher output
   output logic             cd_q,            // Clear-dominant stored output
   output logic             cd_inverted_out, // Clear-dominant complement
   output logic             sd_q,            // Set-dominant stored output
   output logic             sd_inverted_out, // Set-dominant complement
   output logic [31:0]      word_out,        // Shifter result
   output logic             carry_out,       // Last bit shifted out
   output logic             shift_overflow   // Count magnitude above 31
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [31:0] stb_cnt_r;                   // Sampling divider
   logic        stb_r;                       // Evaluation strobe
   logic [7:0]  ctrl_r;                      // Input bits
   logic [31:0] off_ms_r;                    // Off-delay time, ms
   logic [31:0] str_ms_r;                    // Stretch time, ms
   logic [31:0] word_in_r;                   // Shifter input word
   logic [7:0]  shift_count_r;               // Signed shift count
   logic [1:0]  init_q_r;                    // Start output values
   logic        init_go_r;                   // Init pass request
   logic        off_prev_r;                  // Previous off-delay input
   logic        str_prev_r;                  // Previous stretcher input
   logic [31:0] off_cnt_r;                   // Off-delay remaining cycles
   logic [31:0] str_cnt_r;                   // Stretch remaining cycles
   logic [31:0] off_dur;                     // Off-delay in cycles
   logic [31:0] str_dur;                     // Stretch in cycles
   logic        off_in;                      // Off-delay input
   logic        str_in;                      // Stretcher input
   logic        str_clr;                     // Stretcher clear
   logic        acc_wr;                      // Write access completes
   logic        mapped;                      // Address decodes
   logic [31:0] rd_nxt;                      // Read mux
   logic [5:0]  mag;                         // Shift magnitude
   logic [63:0] sh_left;                     // Left shift with carry
   logic [63:0] sh_right;                    // Right shift with carry

   assign off_in  = ctrl_r[cbl_pkg::CTL_OFF_IN];
   assign str_in  = ctrl_r[cbl_pkg::CTL_STR_IN];
   assign str_clr = ctrl_r[cbl_pkg::CTL_STR_CLR];

   ////////////////////////////////////////////////////////////////////////////
   // Millisecond to cycle conversion, never below one cycle
   function automatic logic [31:0] ms_to_cycles(input logic [31:0] ms);
      logic [63:0] prod;
      prod = 64'(ms) * 64'(cbl_pkg::US_PER_MS) / 64'(SAMPLE_US);
      if (prod == 64'h0) begin                 // Zero time: one cycle
         return 32'h0000_0001;
      end else if (prod[63:32] != 32'h0) begin // Saturate to largest count
         return 32'hffff_ffff;
      end
      return prod[31:0];
   endfunction

   assign off_dur = ms_to_cycles(off_ms_r); // RQ4 RQ22
   assign str_dur = ms_to_cycles(str_ms_r); // RQ10 RQ22

   ////////////////////////////////////////////////////////////////////////////
   // Common evaluation strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stb_cnt_r <= 32'h0;
         stb_r     <= 1'b0;
      end else if (stb_cnt_r >= SAMPLE_CLKS - 1) begin // Period reached
         stb_cnt_r <= 32'h0;
         stb_r     <= 1'b1; // RQ23
      end else begin
         stb_cnt_r <= stb_cnt_r + 32'h1;
         stb_r     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave
   assign acc_wr = psel && penable && pwrite && pready;

   always_comb begin
      mapped = 1'b1;
      rd_nxt = 32'h0;
      if (paddr == cbl_pkg::OFS_CTRL) begin
         rd_nxt = {24'h0, ctrl_r};
      end else if (paddr == cbl_pkg::OFS_OFFDLY) begin
         rd_nxt = off_ms_r;
      end else if (paddr == cbl_pkg::OFS_STRETCH) begin
         rd_nxt = str_ms_r;
      end else if (paddr == cbl_pkg::OFS_WORD_IN) begin
         rd_nxt = word_in_r;
      end else if (paddr == cbl_pkg::OFS_COUNT) begin
         rd_nxt = {24'h0, shift_count_r};
      end else if (paddr == cbl_pkg::OFS_STATUS) begin
         rd_nxt = {24'h0, shift_overflow, carry_out, sd_inverted_out, sd_q,
                   cd_inverted_out, cd_q, stretch_q, off_delay_q};
      end else if (paddr == cbl_pkg::OFS_WORDOUT) begin
         rd_nxt = word_out;
      end else if (paddr == cbl_pkg::OFS_INIT) begin
         rd_nxt = {30'h0, init_q_r};
      end else begin                         // Unmapped
         mapped = 1'b0;
      end
   end

   // Ready and data in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         prdata  <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Register writes, defaults zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r        <= cbl_pkg::RST_CTRL;
         off_ms_r      <= cbl_pkg::RST_WORD; // RQ21
         str_ms_r      <= cbl_pkg::RST_WORD; // RQ21
         word_in_r     <= cbl_pkg::RST_WORD;
         shift_count_r <= 8'h00;
         init_q_r      <= 2'b00;
         init_go_r     <= 1'b0;
      end else begin
         if (acc_wr && paddr == cbl_pkg::OFS_CTRL) begin
            ctrl_r <= pwdata[7:0];
         end
         if (acc_wr && paddr == cbl_pkg::OFS_OFFDLY) begin
            off_ms_r <= pwdata;
         end
         if (acc_wr && paddr == cbl_pkg::OFS_STRETCH) begin
            str_ms_r <= pwdata;
         end
         if (acc_wr && paddr == cbl_pkg::OFS_WORD_IN) begin
            word_in_r <= pwdata;
         end
         if (acc_wr && paddr == cbl_pkg::OFS_COUNT) begin
            shift_count_r <= pwdata[7:0];
         end
         if (acc_wr && paddr == cbl_pkg::OFS_INIT) begin
            init_q_r  <= pwdata[1:0];
            init_go_r <= pwdata[cbl_pkg::INI_GO];
         end else begin                      // Go bit self-clears
            init_go_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobe output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_strobe <= 1'b0;
      end else begin
         cycle_strobe <= stb_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Off-delay timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         off_delay_q <= 1'b0;
         off_prev_r  <= 1'b0;
         off_cnt_r   <= 32'h0;
      end else if (init_go_r) begin          // Initialization pass
         off_prev_r  <= off_in; // RQ5
         off_delay_q <= init_q_r[cbl_pkg::INI_OFF_Q];
         off_cnt_r   <= init_q_r[cbl_pkg::INI_OFF_Q] ? off_dur : 32'h0; // RQ6
      end else if (stb_r) begin
         off_prev_r <= off_in; // RQ23
         if (off_in) begin                   // High input forces high
            off_delay_q <= 1'b1; // RQ2
            off_cnt_r   <= 32'h0; // RQ3
         end else if (off_prev_r) begin      // Falling edge starts delay
            off_delay_q <= 1'b1; // RQ1
            off_cnt_r   <= off_dur;
         end else if (off_cnt_r > 32'h1) begin // Still running
            off_cnt_r <= off_cnt_r - 32'h1; // RQ22
         end else begin                      // Elapsed
            off_delay_q <= 1'b0; // RQ1
            off_cnt_r   <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pulse stretcher
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stretch_q  <= 1'b0;
         str_prev_r <= 1'b0;
         str_cnt_r  <= 32'h0;
      end else if (str_clr) begin            // Clear wins at once
         stretch_q <= 1'b0; // RQ9
         str_cnt_r <= 32'h0;
         if (stb_r || init_go_r) begin
            str_prev_r <= str_in;
         end
      end else if (init_go_r) begin          // Initialization pass
         str_prev_r <= str_in; // RQ11
         stretch_q  <= init_q_r[cbl_pkg::INI_STR_Q];
         str_cnt_r  <= init_q_r[cbl_pkg::INI_STR_Q] ? str_dur : 32'h0; // RQ12
      end else if (stb_r) begin
         str_prev_r <= str_in;
         if (str_in && !str_prev_r) begin    // Rising edge
            stretch_q <= 1'b1; // RQ7
            str_cnt_r <= str_dur;
         end else if (str_cnt_r > 32'h1) begin // Duration running
            str_cnt_r <= str_cnt_r - 32'h1; // RQ22
         end else begin                      // Duration over
            str_cnt_r <= 32'h0;
            if (!str_in) begin
               stretch_q <= 1'b0; // RQ8
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clear-dominant flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cd_q            <= 1'b0;
         cd_inverted_out <= 1'b1; // RQ16
      end else if (stb_r) begin
         if (ctrl_r[cbl_pkg::CTL_CD_CLR]) begin   // Clear dominates
            cd_q            <= 1'b0; // RQ14
            cd_inverted_out <= 1'b1; // RQ16
         end else if (ctrl_r[cbl_pkg::CTL_CD_SET]) begin
            cd_q            <= 1'b1; // RQ13
            cd_inverted_out <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Set-dominant flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sd_q            <= 1'b0;
         sd_inverted_out <= 1'b1; // RQ16
      end else if (stb_r) begin
         if (ctrl_r[cbl_pkg::CTL_SD_SET]) begin   // Set dominates
            sd_q            <= 1'b1; // RQ15
            sd_inverted_out <= 1'b0; // RQ16
         end else if (ctrl_r[cbl_pkg::CTL_SD_CLR]) begin
            sd_q            <= 1'b0; // RQ13
            sd_inverted_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word shifter
   assign mag      = shift_count_r[7] ? 6'(8'h00 - shift_count_r) : shift_count_r[5:0];
   assign sh_left  = {32'h0, word_in_r} << mag; // RQ17 RQ18
   assign sh_right = {word_in_r, 32'h0} >> mag; // RQ17 RQ18

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_out       <= cbl_pkg::RST_WORD;
         carry_out      <= 1'b0;
         shift_overflow <= 1'b0;
      end else if (stb_r) begin
         if (shift_count_r[6:5] != {2{shift_count_r[7]}} || mag > cbl_pkg::SHIFT_MAX) begin
            word_out       <= 32'h0; // RQ20
            carry_out      <= 1'b0;
            shift_overflow <= 1'b1;
         end else if (shift_count_r[7]) begin    // Right, logical
            word_out       <= sh_right[63:32];
            carry_out      <= sh_right[31]; // RQ19
            shift_overflow <= 1'b0;
         end else begin                          // Left, zero count too
            word_out       <= sh_left[31:0];
            carry_out      <= sh_left[32]; // RQ19
            shift_overflow <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_OFF_HIGH: assert property (stb_r && !init_go_r && off_in |=> off_delay_q) // RQ2
      else $error("off-delay output not high with input high");
   AST_OFF_HOLD: assert property (stb_r && !init_go_r && !off_in && off_cnt_r > 32'h1
                                  |=> off_delay_q && off_cnt_r == $past(off_cnt_r) - 32'h1) // RQ1
      else $error("off-delay dropped or miscounted early");
   AST_OFF_END: assert property (stb_r && !init_go_r && !off_in && !off_prev_r
                                 && off_cnt_r <= 32'h1 |=> !off_delay_q) // RQ4
      else $error("off-delay did not end");
   AST_STR_SET: assert property (stb_r && !init_go_r && !str_clr && str_in && !str_prev_r
                                 |=> stretch_q && str_cnt_r == $past(str_dur)) // RQ7
      else $error("stretcher not set on rising edge");
   AST_STR_CLR: assert property (str_clr |=> !stretch_q) // RQ9
      else $error("stretcher clear ignored");
   AST_STR_HOLD: assert property (stb_r && !str_clr && !init_go_r && stretch_q && str_in
                                  |=> stretch_q) // RQ8
      else $error("stretcher fell with input high");
   AST_CD_BOTH: assert property (stb_r && ctrl_r[cbl_pkg::CTL_CD_SET]
                                 && ctrl_r[cbl_pkg::CTL_CD_CLR] |=> !cd_q) // RQ14
      else $error("clear-dominant not low with both high");
   AST_SD_BOTH: assert property (stb_r && ctrl_r[cbl_pkg::CTL_SD_SET]
                                 && ctrl_r[cbl_pkg::CTL_SD_CLR] |=> sd_q) // RQ15
      else $error("set-dominant not high with both high");
   AST_INV: assert property (cd_inverted_out != cd_q && sd_inverted_out != sd_q) // RQ16
      else $error("inverted output not complement");
   AST_ZERO_CNT: assert property (stb_r && shift_count_r == 8'h00
                                  |=> !carry_out && word_out == $past(word_in_r)) // RQ19
      else $error("zero count altered word or carry");
   AST_OVF: assert property (stb_r && mag > cbl_pkg::SHIFT_MAX
                             |=> shift_overflow && word_out == 32'h0 && !carry_out) // RQ20
      else $error("overflow not flagged");
   AST_STB_GAP: assert property (stb_r |=> !stb_r || SAMPLE_CLKS == 1) // RQ23
      else $error("strobe too long");

   COV_OFF_FALL: cover property (stb_r && off_prev_r && !off_in ##[1:1000] !off_delay_q);
   COV_STR_CLR:  cover property (stretch_q ##1 str_clr ##1 !stretch_q);
   COV_OVF:      cover property (shift_overflow);
   COV_RIGHT:    cover property (stb_r && shift_count_r[7] ##1 carry_out);

endmodule : cbl_logic_blocks
`default_nettype wire

// ==== rtl/cbl_pkg.sv ====
package cbl_pkg;
   // Clock and sampling timing
   localparam int unsigned CLK_MHZ         = 100;        // Pclk rate in MHz
   localparam int unsigned SAMPLE_US_DEF   = 1000;       // Evaluation period in us
   localparam int unsigned SAMPLE_CLKS_DEF = SAMPLE_US_DEF * CLK_MHZ; // Pclk per cycle
   localparam int unsigned US_PER_MS       = 1000;       // Microseconds per millisecond
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;           // Logic inputs
   localparam logic [7:0] OFS_OFFDLY  = 8'h04;           // Off-delay time, ms
   localparam logic [7:0] OFS_STRETCH = 8'h08;           // Stretch time, ms
   localparam logic [7:0] OFS_WORD_IN = 8'h0c;           // Shifter input word
   localparam logic [7:0] OFS_COUNT   = 8'h10;           // Signed shift count
   localparam logic [7:0] OFS_STATUS  = 8'h14;           // Output bits
   localparam logic [7:0] OFS_WORDOUT = 8'h18;           // Shifter result
   localparam logic [7:0] OFS_INIT    = 8'h1c;           // Initialization pass
   // Control register fields
   localparam int CTL_OFF_IN  = 0;                       // Off-delay input pulse
   localparam int CTL_STR_IN  = 1;                       // Stretcher input pulse
   localparam int CTL_STR_CLR = 2;                       // Stretcher clear
   localparam int CTL_CD_SET  = 3;                       // Clear-dominant set
   localparam int CTL_CD_CLR  = 4;                       // Clear-dominant clear
   localparam int CTL_SD_SET  = 5;                       // Set-dominant set
   localparam int CTL_SD_CLR  = 6;                       // Set-dominant clear
   // Init register fields
   localparam int INI_OFF_Q   = 0;                       // Off-delay start output
   localparam int INI_STR_Q   = 1;                       // Stretcher start output
   localparam int INI_GO      = 2;                       // Write 1 runs the pass
   // Reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;    // Words and times
   localparam logic [7:0]  RST_CTRL  = 8'h00;            // Inputs low
   localparam logic [5:0]  SHIFT_MAX = 6'h1f;            // Largest legal magnitude
endpackage : cbl_pkg
